//--- verilog/scp_pkg.sv
// Function
// - port 4 over-current input is active low
// - clock pin: eeprom master if mode 1, else target
// - data pin: eeprom master if mode 1, else target
// - mode strap sampled at reset release
// - mode pin drives superspeed suspend when enabled
// - power management strap 0 enables switching, overcurrent
// - four power outputs control port power
// - smbus mode: power strap gives address bit 1
// - power pin drives superspeed connect when enabled
// - polarity strap: 0 active low, 1 high
// - power pins sampled give per-port charge support
// - ganged strap: 0 individual, 1 ganged, addr bit2
package scp_pkg;
   localparam int SCP_PORTS = 4;
   localparam logic [1:0] SCP_SYNC_RESET = 2'h0;
   localparam logic [1:0] SCP_CAPTURE_WAIT = 2'h2;
   localparam logic SCP_MODE_EEPROM = 1'h1;
   localparam logic SCP_PWR_ENABLED = 1'h0;
   localparam logic SCP_POL_HIGH = 1'h1;
   localparam int SCP_ADDR_BIT1 = 1;
   localparam int SCP_ADDR_BIT2 = 2;

   typedef struct packed {
      logic eeprom_mode;
      logic full_power_mgmt_n;
      logic power_control_polarity;
      logic ganged;
      logic [3:0] port_charge_enable_strap;
   } scp_straps_t;

   localparam scp_straps_t SCP_STRAPS_RESET = '{1'h1, 1'h1, 1'h1, 1'h0,
      4'h0};

   typedef struct packed {
      logic i;
      logic o;
      logic oe;
   } scp_pin_t;
endpackage

//--- verilog/scp_sync.sv
module scp_sync (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] d,
   output logic [7:0] q
);
   import scp_pkg::*;
   logic [7:0] meta_r;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_r <= 8'h00;
         q <= 8'h00;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

//--- verilog/scp_strap_pins.sv
module scp_strap_pins (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic port4_overcurrent_n,
   input wire logic serial_mode_select_n_i,
   output logic serial_mode_select_n_o,
   output logic serial_mode_select_n_oe,
   input wire logic full_power_mgmt_n_i,
   output logic full_power_mgmt_n_o,
   output logic full_power_mgmt_n_oe,
   input wire logic power_control_polarity,
   input wire logic target_address_bit2,
   input wire logic [3:0] port_power_control_i,
   output logic [3:0] port_power_control_o,
   output logic [3:0] port_power_control_oe,
   input wire logic feature_status_en,
   input wire logic ss_suspended,
   input wire logic ss_connected,
   input wire logic [3:0] port_power_on,
   input wire logic eng_clk_o,
   input wire logic eng_clk_oe,
   input wire logic eng_data_o,
   input wire logic eng_data_oe,
   output logic eeprom_clk_o,
   output logic eeprom_clk_oe,
   output logic eeprom_data_o,
   output logic eeprom_data_oe,
   output logic target_clk_in,
   output logic target_data_in,
   input wire logic serial_clk_i,
   input wire logic serial_data_i,
   output scp_pkg::scp_straps_t straps,
   output logic [6:0] target_address_low,
   output logic overcurrent4,
   output logic power_switching_en
);
   import scp_pkg::*;

   logic [7:0] sync_q;
   logic straps_done_r;
   logic clk_s_r;
   logic data_s_r;
   logic clk_m_r;
   logic data_m_r;
   scp_straps_t straps_r;

   scp_sync u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .d({port4_overcurrent_n, serial_mode_select_n_i,
          full_power_mgmt_n_i, power_control_polarity,
          port_power_control_i}),
      .q(sync_q)
   );

   // address/ganged pins share sampling with other straps in one cycle
   logic addr2_m_r;
   logic addr2_s_r;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         addr2_m_r <= 1'h0;
         addr2_s_r <= 1'h0;
         clk_m_r <= 1'h0;
         clk_s_r <= 1'h0;
         data_m_r <= 1'h0;
         data_s_r <= 1'h0;
      end else begin
         addr2_m_r <= target_address_bit2;
         addr2_s_r <= addr2_m_r;
         clk_m_r <= serial_clk_i;
         clk_s_r <= clk_m_r;
         data_m_r <= serial_data_i;
         data_s_r <= data_m_r;
      end
   end

   // capture: sync stages are filled two edges after release
   logic [1:0] wait_r;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wait_r <= SCP_SYNC_RESET;
         straps_done_r <= 1'h0;
      end else if (!straps_done_r) begin
         wait_r <= wait_r + 2'h1;
         if (wait_r == SCP_CAPTURE_WAIT)
            straps_done_r <= 1'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         straps_r <= SCP_STRAPS_RESET;
      end else if (!straps_done_r && wait_r == SCP_CAPTURE_WAIT) begin
         straps_r.eeprom_mode <= sync_q[6];
         straps_r.full_power_mgmt_n <= sync_q[5];
         straps_r.power_control_polarity <= sync_q[4];
         straps_r.ganged <= addr2_s_r;
         straps_r.port_charge_enable_strap <= sync_q[3:0];
      end
   end
   // straps_r never loads again once straps_done_r is set

   assign straps = straps_r;
   assign power_switching_en = straps_done_r &&
      (straps_r.full_power_mgmt_n == SCP_PWR_ENABLED);
   assign overcurrent4 = power_switching_en && !sync_q[7];

   // smbus address low bits from straps
   always_comb begin
      target_address_low = 7'h00;
      target_address_low[SCP_ADDR_BIT1] = straps_r.full_power_mgmt_n;
      target_address_low[SCP_ADDR_BIT2] = straps_r.ganged;
   end

   wire eeprom_sel = straps_done_r &&
      (straps_r.eeprom_mode == SCP_MODE_EEPROM);
   assign eeprom_clk_o = eng_clk_o;
   assign eeprom_clk_oe = eeprom_sel && eng_clk_oe;
   assign eeprom_data_o = eng_data_o;
   assign eeprom_data_oe = eeprom_sel && eng_data_oe;
   assign target_clk_in = eeprom_sel ? 1'h1 : clk_s_r;
   assign target_data_in = eeprom_sel ? 1'h1 : data_s_r;

   wire status_on = straps_done_r && feature_status_en;
   assign serial_mode_select_n_o = ss_suspended;
   assign serial_mode_select_n_oe = status_on;
   assign full_power_mgmt_n_o = ss_connected;
   assign full_power_mgmt_n_oe = status_on;

   // power outputs with polarity, only driven when switching enabled
   always_ff @(posedge core_clk) begin
      if (rst) begin
         port_power_control_o <= 4'h0;
         port_power_control_oe <= 4'h0;
      end else begin
         port_power_control_o <= (straps_r.power_control_polarity ==
            SCP_POL_HIGH) ? port_power_on : ~port_power_on;
         port_power_control_oe <= {SCP_PORTS{power_switching_en}};
      end
   end

   AST_OC_LOW: assert property (@(posedge core_clk) disable iff (rst)
      power_switching_en && !sync_q[7] |-> overcurrent4)
      else $error("overcurrent not flagged");
   AST_OC_OFF: assert property (@(posedge core_clk) disable iff (rst)
      !power_switching_en |-> !overcurrent4)
      else $error("overcurrent while disabled");
   AST_EE_CLK: assert property (@(posedge core_clk) disable iff (rst)
      !eeprom_sel |-> !eeprom_clk_oe)
      else $error("clock driven in target mode");
   AST_EE_DATA: assert property (@(posedge core_clk) disable iff (rst)
      eeprom_sel && eng_data_oe |-> eeprom_data_oe)
      else $error("data not driven in eeprom mode");
   AST_EE_OFF: assert property (@(posedge core_clk) disable iff (rst)
      !eeprom_sel |-> !eeprom_data_oe)
      else $error("data driven in target mode");
   AST_STABLE: assert property (@(posedge core_clk) disable iff (rst)
      straps_done_r |=> $stable(straps_r))
      else $error("strap changed after capture");
   AST_CAPTURE: assert property (@(posedge core_clk) disable iff (rst)
      $rose(straps_done_r) |-> straps_r.eeprom_mode == $past(sync_q[6]))
      else $error("mode strap not captured");
   AST_CAP_PWR: assert property (@(posedge core_clk) disable iff (rst)
      $rose(straps_done_r) |->
      straps_r.full_power_mgmt_n == $past(sync_q[5]))
      else $error("power strap not captured");
   AST_CAP_POL: assert property (@(posedge core_clk) disable iff (rst)
      $rose(straps_done_r) |->
      straps_r.power_control_polarity == $past(sync_q[4]))
      else $error("polarity strap not captured");
   AST_CAP_CHG: assert property (@(posedge core_clk) disable iff (rst)
      $rose(straps_done_r) |->
      straps_r.port_charge_enable_strap == $past(sync_q[3:0]))
      else $error("charge straps not captured");
   AST_SUSP: assert property (@(posedge core_clk) disable iff (rst)
      serial_mode_select_n_oe |-> serial_mode_select_n_o == ss_suspended)
      else $error("suspend status wrong");
   AST_STATUS: assert property (@(posedge core_clk) disable iff (rst)
      status_on |-> serial_mode_select_n_oe && full_power_mgmt_n_oe)
      else $error("status outputs not driven");
   AST_CONN: assert property (@(posedge core_clk) disable iff (rst)
      !status_on |-> !full_power_mgmt_n_oe)
      else $error("connect status driven early");
   AST_POL: assert property (@(posedge core_clk) disable iff (rst)
      straps_done_r && !straps_r.power_control_polarity ##1
      !straps_r.power_control_polarity |->
      port_power_control_o == ~$past(port_power_on))
      else $error("polarity wrong");
   AST_PWR_OE: assert property (@(posedge core_clk) disable iff (rst)
      power_switching_en ##1 power_switching_en |->
      port_power_control_oe == 4'hf)
      else $error("power not driven");
   AST_PWR_OFF: assert property (@(posedge core_clk) disable iff (rst)
      !power_switching_en ##1 !power_switching_en |->
      port_power_control_oe == 4'h0)
      else $error("power driven while disabled");
   // address bits must follow the pins as they stood at capture
   AST_ADDR: assert property (@(posedge core_clk) disable iff (rst)
      $rose(straps_done_r) && !straps_r.eeprom_mode |->
      target_address_low[SCP_ADDR_BIT1] == $past(sync_q[5]))
      else $error("address bit1 wrong");
   AST_ADDR2: assert property (@(posedge core_clk) disable iff (rst)
      $rose(straps_done_r) |->
      target_address_low[SCP_ADDR_BIT2] == $past(addr2_s_r))
      else $error("address bit2 wrong");
   AST_TGT_EE: assert property (@(posedge core_clk) disable iff (rst)
      eeprom_sel |-> target_clk_in && target_data_in)
      else $error("target inputs not parked");
   AST_TGT_SMB: assert property (@(posedge core_clk) disable iff (rst)
      !eeprom_sel |-> target_clk_in == clk_s_r && target_data_in == data_s_r)
      else $error("target inputs not passed");

   CV_EEPROM: cover property (@(posedge core_clk) disable iff (rst)
      $rose(straps_done_r) && straps_r.eeprom_mode);
   CV_SMBUS: cover property (@(posedge core_clk) disable iff (rst)
      $rose(straps_done_r) && !straps_r.eeprom_mode);
   CV_OC: cover property (@(posedge core_clk) disable iff (rst)
      overcurrent4);
   CV_STATUS: cover property (@(posedge core_clk) disable iff (rst)
      serial_mode_select_n_oe && ss_suspended);
   CV_POL_LOW: cover property (@(posedge core_clk) disable iff (rst)
      power_switching_en && !straps_r.power_control_polarity);
endmodule

//--- tb/scp_far_end.sv
module scp_far_end (
   input wire logic hold,
   input wire logic [7:0] strap,
   input wire logic mode_o,
   input wire logic mode_oe,
   input wire logic pwr_o,
   input wire logic pwr_oe,
   input wire logic [3:0] ctl_o,
   input wire logic [3:0] ctl_oe,
   output logic mode_i,
   output logic pwr_i,
   output logic pol,
   output logic gang,
   output logic [3:0] ctl_i
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] ctl_pull;
   // straps are driven only around reset, then the pulls take over
   assign mode_i = mode_oe ? mode_o : (hold ? strap[0] : 1'b1);
   assign pwr_i = pwr_oe ? pwr_o : (hold ? strap[1] : 1'b0);
   assign pol = hold ? strap[2] : 1'b1;
   assign gang = hold ? strap[3] : 1'b0;
   assign ctl_pull = hold ? strap[7:4] : 4'h0;
   assign ctl_i = (ctl_oe & ctl_o) | (~ctl_oe & ctl_pull);
endmodule

//--- tb/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import scp_pkg::*;
   logic core_clk = 0, rst = 1, hold = 1;
   logic [7:0] st = 0;
   logic [7:0] xs, xe;
   logic [15:0] rin = 0;
   logic [31:0] seed;
   int mismatches = 0, tests_run = 0, cyc = 0, n, m;
   logic sw, mode_i, mode_o, mode_oe, pwr_i, pwr_o, pwr_oe, pol, gang;
   logic eck_o, eck_oe, edt_o, edt_oe, tclk, tdat, oc4, psw;
   logic [3:0] ctl_i, ctl_o, ctl_oe;
   logic [6:0] addr;
   scp_straps_t straps;
   always #25 core_clk = ~core_clk;
   scp_far_end u_far (.hold(hold), .strap(st), .mode_o(mode_o),
      .mode_oe(mode_oe), .pwr_o(pwr_o), .pwr_oe(pwr_oe), .ctl_o(ctl_o),
      .ctl_oe(ctl_oe), .mode_i(mode_i), .pwr_i(pwr_i), .pol(pol),
      .gang(gang), .ctl_i(ctl_i));
   scp_strap_pins u_dut (.core_clk(core_clk), .rst(rst),
      .port4_overcurrent_n(rin[0]), .serial_mode_select_n_i(mode_i),
      .serial_mode_select_n_o(mode_o), .serial_mode_select_n_oe(mode_oe),
      .full_power_mgmt_n_i(pwr_i), .full_power_mgmt_n_o(pwr_o),
      .full_power_mgmt_n_oe(pwr_oe), .power_control_polarity(pol),
      .target_address_bit2(gang), .port_power_control_i(ctl_i),
      .port_power_control_o(ctl_o), .port_power_control_oe(ctl_oe),
      .feature_status_en(rin[1]), .ss_suspended(rin[2]),
      .ss_connected(rin[3]), .port_power_on(rin[7:4]),
      .eng_clk_o(rin[8]), .eng_clk_oe(rin[9]), .eng_data_o(rin[10]),
      .eng_data_oe(rin[11]), .eeprom_clk_o(eck_o), .eeprom_clk_oe(eck_oe),
      .eeprom_data_o(edt_o), .eeprom_data_oe(edt_oe),
      .target_clk_in(tclk), .target_data_in(tdat),
      .serial_clk_i(rin[12]), .serial_data_i(rin[13]), .straps(straps),
      .target_address_low(addr), .overcurrent4(oc4),
      .power_switching_en(psw));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 2000) begin
         mismatches++;
         test_done;
      end
   end
   initial begin
      seed = 32'h0001_216f;
      repeat (16) @(negedge core_clk);
      for (n = 0; n < 8; n++) begin
         seed = lfsr(seed);
         st = seed[7:0];
         if (st[7:4] != 4'h0) st[1] = 1'b0;
         sw = ~st[1];
         rst = 1;
         hold = 1;
         repeat (2) @(negedge core_clk);
         rst = 0;
         repeat (4) @(negedge core_clk);
         hold = 0;
         repeat (3) @(negedge core_clk);
         xs = {st[0], st[1], st[2], st[3], st[7:4]};
         check(straps, xs);
         check(8'(psw), 8'(sw));
         if (!st[0]) check(8'(addr[2:1]), 8'({st[3], st[1]}));
         for (m = 0; m < 6; m++) begin
            seed = lfsr(seed);
            rin = seed[15:0];
            repeat (4) @(negedge core_clk);
            check(8'(oc4), 8'(~rin[0] & sw));
            check(8'(ctl_oe), 8'({4{sw}}));
            xe = {4'h0, st[2] ? rin[7:4] : 4'(~rin[7:4])};
            if (sw) check(8'(ctl_o), xe);
            check(8'({mode_oe, pwr_oe}), 8'({2{rin[1]}}));
            xe = {6'h00, rin[2], rin[3]};
            if (rin[1]) check(8'({mode_o, pwr_o}), xe);
            xe = st[0] ? {6'h00, rin[9], rin[11]} : 8'h00;
            check(8'({eck_oe, edt_oe}), xe);
            xe = {6'h00, rin[8], rin[10]};
            if (st[0]) check(8'({eck_o, edt_o}), xe);
            check(8'({tdat, tclk}), st[0] ? 8'h03 : 8'(rin[13:12]));
         end
         check(straps, xs);
         $display("round %0d done", n);
      end
      test_done;
   end
endmodule
